//--- common/txdma_pkg.sv
// Purpose: Shared constants and carrier types for the transmitter DMA request logic.
// Assumes: Two channels, sixteen-character transmitter FIFO.
// Notes:   Nothing here holds state.

package txdma_pkg;

  // ****************************************
  // Constants
  // ****************************************
  localparam int unsigned NUM_CHANNELS    = 2;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned LEVEL_W         = 5;
  localparam logic        REQ_N_RESET     = 1'b1;
  localparam logic        MODE_RESET      = 1'b0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    TXDMA_MODE0 = 1'b0,
    TXDMA_MODE1 = 1'b1
  } txdma_mode_e;

  // Per-channel view of the transmitter and its FIFO control bits.
  typedef struct packed {
    logic                 fifo_enable_bit;
    logic                 dma_mode_select_bit;
    logic [LEVEL_W-1:0]   tx_level;
    logic                 tx_write;
  } txdma_chan_s;

endpackage : txdma_pkg

//--- rtl/txdma_ready.sv
// Purpose: Drives the active-low transmitter DMA request of each channel.
// Assumes: Channel status comes from logic on core_clk; no resynchronising needed.
// Notes:   Outputs are registered, so they follow status by one clock.
//
// What this block does
// - FIFO mode picks mode by select bit.
// - FIFOs disabled forces mode 0.
// - Mode 0: request low when transmitter empty.
// - Mode 0: request high on first character written.
// - Mode 1: request low when FIFO empty.
// - Mode 1: stays low until FIFO full.

`timescale 1ns/1ps

module txdma_ready #(
  parameter int unsigned DEPTH = txdma_pkg::FIFO_DEPTH
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      clk_en,
  input  wire txdma_pkg::txdma_chan_s    ch0_status,
  input  wire txdma_pkg::txdma_chan_s    ch1_status,
  output logic                           ch0_tx_dma_request_n,
  output logic                           ch1_tx_dma_request_n
);

  // ****************************************
  // Elaboration checks
  // ****************************************

  // The level field must be able to hold the full count, and a zero depth has no meaning.
  if (DEPTH < 1 || DEPTH >= (1 << txdma_pkg::LEVEL_W)) begin : g_bad_depth
    $error("DEPTH does not fit the level field.");
  end

  // The output stage below is written out for exactly two channels.
  if (txdma_pkg::NUM_CHANNELS != 2) begin : g_bad_channels
    $error("The output stage serves exactly two channels.");
  end

  // ****************************************
  // Local constants and types
  // ****************************************
  localparam int unsigned NCH = txdma_pkg::NUM_CHANNELS;
  localparam int unsigned LW  = txdma_pkg::LEVEL_W;

  localparam logic [LW-1:0] FULL_LEVEL  = DEPTH[LW-1:0];
  localparam logic [LW-1:0] EMPTY_LEVEL = '0;

  // Request state of one channel: idle means the output stands high.
  typedef enum logic [0:0] {
    TXDMA_REQ_IDLE   = 1'b0,
    TXDMA_REQ_ACTIVE = 1'b1
  } txdma_req_state_e;

  localparam txdma_req_state_e REQ_STATE_RESET =
    (txdma_pkg::REQ_N_RESET == 1'b1) ? TXDMA_REQ_IDLE : TXDMA_REQ_ACTIVE;

  // ****************************************
  // Per-channel signals
  // ****************************************
  txdma_pkg::txdma_chan_s status    [NCH];
  txdma_pkg::txdma_mode_e mode      [NCH];
  logic                   is_empty  [NCH];
  logic                   is_full   [NCH];
  logic                   wrote     [NCH];
  txdma_req_state_e       state_ff  [NCH];
  txdma_req_state_e       nxt_state [NCH];
  logic                   nxt_req_n [NCH];

  assign status[0] = ch0_status;
  assign status[1] = ch1_status;

  // ****************************************
  // Per-channel request logic
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_chan

    // Compatibility mode ignores the select bit so old drivers keep working.
    always_comb begin
      mode[c] = txdma_pkg::TXDMA_MODE0;
      case ({status[c].fifo_enable_bit, status[c].dma_mode_select_bit})
        2'b11: begin
          mode[c] = txdma_pkg::TXDMA_MODE1;
        end
        2'b10: begin
          mode[c] = txdma_pkg::TXDMA_MODE0;
        end
        2'b01: begin
          mode[c] = txdma_pkg::TXDMA_MODE0;
        end
        2'b00: begin
          mode[c] = txdma_pkg::TXDMA_MODE0;
        end
        default: begin
          mode[c] = txdma_pkg::TXDMA_MODE0;
        end
      endcase
    end

    // Occupancy decode; full uses at-or-above so an overfilled count never re-arms.
    always_comb begin
      is_empty[c] = (status[c].tx_level == EMPTY_LEVEL);
      is_full[c]  = (status[c].tx_level >= FULL_LEVEL);
      wrote[c]    = status[c].tx_write;
    end

    // Next request state for the mode in force this cycle.
    always_comb begin
      nxt_state[c] = state_ff[c];
      case (mode[c])
        txdma_pkg::TXDMA_MODE0: begin
          // A write in the same cycle as empty wins, so one request means one byte.
          if (wrote[c] || !is_empty[c]) begin
            nxt_state[c] = TXDMA_REQ_IDLE;
          end else begin
            nxt_state[c] = TXDMA_REQ_ACTIVE;
          end
        end
        txdma_pkg::TXDMA_MODE1: begin
          // Between empty and full the request holds, so a burst is never cut short.
          if (is_full[c]) begin
            nxt_state[c] = TXDMA_REQ_IDLE;
          end else if (is_empty[c]) begin
            nxt_state[c] = TXDMA_REQ_ACTIVE;
          end else begin
            nxt_state[c] = state_ff[c];
          end
        end
        default: begin
          nxt_state[c] = REQ_STATE_RESET;
        end
      endcase
    end

    // The pin level is the inverse of the active state.
    always_comb begin
      nxt_req_n[c] = (nxt_state[c] != TXDMA_REQ_ACTIVE);
    end

    // State register; reset acts whatever the clock enable holds.
    always_ff @(posedge core_clk) begin
      if (rst) begin
        state_ff[c] <= REQ_STATE_RESET;
      end else if (clk_en) begin
        state_ff[c] <= nxt_state[c];
      end
    end

  end

  // ****************************************
  // Outputs
  // ****************************************

  // Each pin has its own flip-flop so the controller never sees a decode glitch.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch0_tx_dma_request_n <= txdma_pkg::REQ_N_RESET;
    end else if (clk_en) begin
      ch0_tx_dma_request_n <= nxt_req_n[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch1_tx_dma_request_n <= txdma_pkg::REQ_N_RESET;
    end else if (clk_en) begin
      ch1_tx_dma_request_n <= nxt_req_n[1];
    end
  end

endmodule : txdma_ready

//--- verification/txdma_ready_sva.sv
// Purpose: Assertions on the request outputs.
// Assumes: Status is sampled on core_clk.
// Notes:   Channel 1 is spot-checked.
`timescale 1ns/1ps
module txdma_ready_sva #(parameter int unsigned DEPTH = 16) (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   clk_en,
  input wire txdma_pkg::txdma_chan_s ch0_status,
  input wire txdma_pkg::txdma_chan_s ch1_status,
  input wire logic                   ch0_tx_dma_request_n,
  input wire logic                   ch1_tx_dma_request_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic       m1 = ch0_status.fifo_enable_bit & ch0_status.dma_mode_select_bit;
  wire logic [4:0] lv = ch0_status.tx_level;
  wire logic       wr = ch0_status.tx_write;
  m0_empty_a: assert property (clk_en && !m1 && lv == 0 && !wr |=> !ch0_tx_dma_request_n)
    else $error("mode 0 request missing");
  m0_load_a: assert property (clk_en && !m1 && (lv != 0 || wr) |=> ch0_tx_dma_request_n)
    else $error("mode 0 request not dropped");
  m1_empty_a: assert property (clk_en && m1 && lv == 0 |=> !ch0_tx_dma_request_n)
    else $error("mode 1 request missing");
  m1_full_a: assert property (clk_en && m1 && lv >= DEPTH |=> ch0_tx_dma_request_n)
    else $error("mode 1 request not dropped");
  m1_hold_a: assert property (clk_en && m1 && lv != 0 && lv < DEPTH |=> $stable(ch0_tx_dma_request_n))
    else $error("mode 1 request moved");
  ch1_empty_a: assert property (clk_en && ch1_status.tx_level == 0 && !ch1_status.tx_write
    |=> !ch1_tx_dma_request_n)
    else $error("channel 1 request missing");
  cover property (m1 && lv >= DEPTH);
  cover property (!m1 && wr);
  cover property ($fell(ch1_tx_dma_request_n));
endmodule : txdma_ready_sva

//--- verification/txdma_dma_ctrl.sv
// Purpose: DMA controller that fills the transmitter on request.
// Assumes: Driver changes after the falling edge.
// Notes:   Drain stands in for the serialiser.
`timescale 1ns/1ps
module txdma_dma_ctrl (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               req_n,
  input  wire logic               fe,
  input  wire logic               sel,
  input  wire logic               drain,
  output txdma_pkg::txdma_chan_s  st
);
  logic w;
  assign w = !rst && !req_n && st.tx_level < 5'(txdma_pkg::FIFO_DEPTH);
  // A write lands before the next sample, so one request yields one write in mode 0 while clk_en is high.
  always @(negedge core_clk) begin
    st <= {fe, sel, rst ? 5'h0 : 5'(st.tx_level + w - (drain && st.tx_level != 0)), w};
  end
endmodule : txdma_dma_ctrl

//--- verification/tb_txdma_ready.sv
// Purpose: Random and corner stimulus with per-cycle checks.
// Assumes: One clock of 25 ns.
// Notes:   Expectation is a cycle model.
`timescale 1ns/1ps
module tb_txdma_ready;
  logic core_clk, rst, clk_en, q0, q1, e0, e1;
  logic [1:0] fe, sel, dr;
  txdma_pkg::txdma_chan_s s0, s1;
  int miscompares = 0, num_checks = 0;
  always #12.5 core_clk = ~core_clk;
  txdma_ready u_txdma_ready (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .ch0_status(s0),
    .ch1_status(s1), .ch0_tx_dma_request_n(q0), .ch1_tx_dma_request_n(q1));
  txdma_dma_ctrl u_c0 (.core_clk(core_clk), .rst(rst), .req_n(q0), .fe(fe[0]), .sel(sel[0]),
    .drain(dr[0]), .st(s0));
  txdma_dma_ctrl u_c1 (.core_clk(core_clk), .rst(rst), .req_n(q1), .fe(fe[1]), .sel(sel[1]),
    .drain(dr[1]), .st(s1));
  function automatic logic nxt_req(txdma_pkg::txdma_chan_s s, logic q);
    if (!(s.fifo_enable_bit && s.dma_mode_select_bit)) return s.tx_level != 0 || s.tx_write;
    if (s.tx_level == 0) return 1'b0;
    return s.tx_level >= txdma_pkg::FIFO_DEPTH ? 1'b1 : q;
  endfunction : nxt_req
  always @(posedge core_clk) begin
    e0 <= rst ? 1'b1 : clk_en ? nxt_req(s0, e0) : e0;
    e1 <= rst ? 1'b1 : clk_en ? nxt_req(s1, e1) : e1;
  end
  task automatic check(string n, logic seen, logic exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (num_checks > 0 && miscompares == 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  initial begin
    core_clk = 0; rst = 1; clk_en = 1; fe = 2'h3; sel = 2'h1; dr = 2'h0;
    void'($urandom(60961));
    repeat (4) @(negedge core_clk);
    rst = 0;
    // Burst fill to full on channel 0, single writes on channel 1, then random.
    for (int i = 0; i < 6000; i++) begin
      @(negedge core_clk);
      check("ch0 request", q0, e0);
      check("ch1 request", q1, e1);
      if (i > 60 && i % 200 == 0) {fe, sel} = 4'($urandom);
      dr = i < 60 ? 2'h0 : {$urandom % 4 == 0, $urandom % 3 == 0};
      clk_en = i < 60 || $urandom % 16 != 0;
      rst = i >= 3000 && i < 3003;
    end
    conclude();
  end
endmodule : tb_txdma_ready
bind txdma_ready txdma_ready_sva #(.DEPTH(DEPTH)) u_txdma_ready_sva (.core_clk(core_clk),
  .rst(rst), .clk_en(clk_en), .ch0_status(ch0_status), .ch1_status(ch1_status),
  .ch0_tx_dma_request_n(ch0_tx_dma_request_n), .ch1_tx_dma_request_n(ch1_tx_dma_request_n));
